// [hw/mba_map.svh]
// Offsets, field positions, codes and reset values of the interpreter.
`ifndef MBA_MAP_SVH
`define MBA_MAP_SVH
`define MBA_FC_RW 8'h17
`define MBA_FC_EIT 8'h2B
`define MBA_FC_ERR 8'h80
`define MBA_MEI_OD 8'h0D
`define MBA_EXC_EXT 8'hFF
`define MBA_EXC_OD 8'hCE
`define MBA_EXC_ILLFC 8'h01
`define MBA_EXC_VALUE 8'h03
`define MBA_RW_LEN0 16'h000B
`define MBA_RW_RLEN0 16'h0003
`define MBA_ODERR_LEN 16'h000B
`define MBA_ODERR_XLEN 8'h06
`define MBA_CNT_MIN 16'h0001
`define MBA_CNT_MAX 16'h0079
`define MBA_NODE_MIN 8'h01
`define MBA_NODE_MAX 8'h7F
`define MBA_OD_CNT_MAX 16'h00FD
`define MBA_OD_LOCAL_ERR 32'h0000_0001
`define MBA_PC_MULTI 7
`define MBA_PC_EXT 6
`define MBA_PC_CNTB 5
`define MBA_PC_ACC 0
`define MBA_PC_MUSTZERO 8'h1E
`define MBA_POS_RWDATA 9'h011
`define MBA_REG_STAT 4'h0
`define MBA_REG_MASK 4'h1
`define MBA_REG_CTRL 4'h2
`define MBA_REG_FRAMES 4'h3
`define MBA_CTRL_RST 1'b1
`define MBA_MEM_AW 7
`endif

// [hw/mba_pkg.sv]
// Types shared by the interpreter modules.
package mba_pkg;
  typedef enum logic [2:0] {
    ST_RX = 3'b001,
    ST_OD = 3'b010,
    ST_TX = 3'b100
  } mba_st_t;
  typedef enum logic [3:0] {
    K_RW = 4'b0001,
    K_EXC = 4'b0010,
    K_ODOK = 4'b0100,
    K_ODERR = 4'b1000
  } mba_kind_t;
  typedef struct packed {
    logic vld;
    logic last;
    logic [7:0] data;
  } mba_byte_t;
  typedef struct packed {
    logic vld;
    logic write;
    logic multi;
    logic cnt_on;
    logic [7:0] counter;
    logic [7:0] node;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] start;
    logic [15:0] count;
    logic [31:0] wdata;
    logic [2:0] wlen;
  } mba_od_req_t;
  typedef struct packed {
    logic err;
    logic [31:0] code;
    logic [2:0] rlen;
    logic [31:0] rdata;
  } mba_od_resp_t;
endpackage : mba_pkg

// [hw/mba_regmem.sv]
// Register array reached by the combined read/write function.
`timescale 1ns/1ps
`include "mba_map.svh"
module mba_regmem
  import mba_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Write port
  input wire logic we,
  input wire logic [`MBA_MEM_AW-1:0] waddr,
  input wire logic [15:0] wdata,
  // Read port, data one cycle later
  input wire logic [`MBA_MEM_AW-1:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [2**`MBA_MEM_AW];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : mba_regmem

// [hw/mba_csr.sv]
// Status, mask, control and frame count registers with interrupt.
`timescale 1ns/1ps
`include "mba_map.svh"
module mba_csr
  import mba_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Block side
  input wire logic [2:0] ev,
  input wire logic [15:0] frames,
  output logic en,
  output logic irq
);
  logic [2:0] stat, next_stat, mask, next_mask;
  logic next_en, next_irq;
  logic [15:0] next_rdata;

  always_comb begin
    next_stat = stat;
    next_mask = mask;
    next_en = en;
    next_rdata = 16'h0000;
    if (reg_wr && reg_addr == `MBA_REG_STAT) begin
      next_stat = stat & ~reg_wdata[2:0];
    end
    if (reg_wr && reg_addr == `MBA_REG_MASK) begin
      next_mask = reg_wdata[2:0];
    end
    if (reg_wr && reg_addr == `MBA_REG_CTRL) begin
      next_en = reg_wdata[0];
    end
    // A new event beats a clear arriving in the same cycle.
    next_stat = next_stat | ev;
    if (reg_rd) begin
      unique case (reg_addr)
        `MBA_REG_STAT: next_rdata = {13'h0000, stat};
        `MBA_REG_MASK: next_rdata = {13'h0000, mask};
        `MBA_REG_CTRL: next_rdata = {15'h0000, en};
        `MBA_REG_FRAMES: next_rdata = frames;
        default: next_rdata = 16'h0000;
      endcase
    end
    next_irq = |(next_stat & next_mask);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stat <= 3'h0;
      mask <= 3'h0;
      en <= `MBA_CTRL_RST;
      reg_rdata <= 16'h0000;
      irq <= 1'b0;
    end else begin
      stat <= next_stat;
      mask <= next_mask;
      en <= next_en;
      reg_rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  AST_IRQ: assert property (@(posedge clk_sys) disable iff (!nrst)
    (|(stat & mask)) |-> irq)
    else $error("Interrupt low while an unmasked status bit is set.");
endmodule : mba_csr

// [hw/mba_top.sv]
// Modbus combined read/write and dictionary access interpreter.
`timescale 1ns/1ps
`include "mba_map.svh"
// Overview of operation
// - Read/write request uses code 17h, length 000Bh plus twice write count.
// - Read and write counts must be 0001h to 0079h, else invalid.
// - Reply carries 17h, byte count twice reads, data, length 3 plus count.
// - Dictionary access uses code 2Bh and MEI 0Dh both ways.
// - After MEI come two to four option bytes, then address and data.
// - Options are control bytes, a zero reserved byte, optional counter.
// - Control bits are numbered from the MSB of the first byte.
// - Control bit 0 marks a part of a multi-message transfer.
// - Control bit 1 says whether a second control byte exists.
// - Control bit 2 says whether a counter byte follows reserved byte.
// - Control bit 7 selects read (0) or write (1).
// - Node 01h-7Fh, index high first, subindex, start, count up to 00FDh.
// - Dictionary frames use their own byte order where specified.
// - Dictionary failure answers ABh, FFh, length, 0Dh, CEh, 4-byte code.
module mba_top
  import mba_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Request bytes, MBAP header first
  input wire mba_byte_t rx_in,
  // Response bytes, one every second cycle
  output mba_byte_t tx_out,
  // Dictionary access port
  output mba_od_req_t od_req,
  input wire logic od_done,
  input wire mba_od_resp_t od_resp,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Interrupt
  output logic irq
);
  mba_st_t st, next_st;
  mba_kind_t kind, next_kind;
  logic [23:0][7:0] fb, next_fb;
  logic [8:0] pos, next_pos, txi, next_txi;
  logic tph, next_tph;
  logic [7:0] hi_byte, next_hi_byte, excode, next_excode;
  logic [15:0] rl, next_rl, frames, next_frames;
  logic [31:0] wdat, next_wdat;
  logic [2:0] wlen, next_wlen;
  mba_od_resp_t odr, next_odr;
  mba_byte_t next_tx;
  mba_od_req_t next_req;
  logic [2:0] ev;
  logic en;
  logic mem_we;
  logic [`MBA_MEM_AW-1:0] mem_waddr, mem_raddr;
  logic [15:0] mem_rdata;
  logic [7:0] fc, c0, txb;
  logic [15:0] len, rs, rc, ws, wc, odcnt;
  logic ext, cb, cnt_ok, rw_ok, lenmatch, od_ok, fin;
  logic [4:0] n;
  logic [8:0] dk, di, rk, ttot;

  function automatic logic in_rng(input logic [15:0] v);
    in_rng = v >= `MBA_CNT_MIN && v <= `MBA_CNT_MAX;
  endfunction : in_rng

  // Fixed request fields by byte position.
  assign fc = fb[7];
  assign len = {fb[4], fb[5]};
  assign rs = {fb[8], fb[9]};
  assign rc = {fb[10], fb[11]};
  assign ws = {fb[12], fb[13]};
  assign wc = {fb[14], fb[15]};
  assign cnt_ok = in_rng(rc) && in_rng(wc) &&
    fb[16] == {wc[6:0], 1'b0};
  assign lenmatch = len == ({7'h00, pos} - 16'h0005);
  assign rw_ok = cnt_ok && lenmatch &&
    len == `MBA_RW_LEN0 + {wc[14:0], 1'b0};
  // Control bit n sits at byte bit 7-n.
  assign c0 = fb[9];
  assign ext = c0[`MBA_PC_EXT];
  assign cb = c0[`MBA_PC_CNTB];
  // Node position: MEI, control bytes, reserved byte, optional counter.
  assign n = 5'd11 + {4'h0, ext} + {4'h0, cb};
  assign odcnt = {fb[n + 5'd6], // Low byte may be arriving now.
    pos == {4'h0, n} + 9'd7 ? rx_in.data : fb[n + 5'd7]};
  assign od_ok = fb[8] == `MBA_MEI_OD &&
    (c0 & `MBA_PC_MUSTZERO) == 8'h00 &&
    (!ext || fb[10] == 8'h00) &&
    fb[5'd10 + {4'h0, ext}] == 8'h00 &&
    fb[n] >= `MBA_NODE_MIN && fb[n] <= `MBA_NODE_MAX &&
    odcnt <= `MBA_OD_CNT_MAX && lenmatch &&
    pos >= {4'h0, n} + 9'd7;
  assign fin = st == ST_RX && rx_in.vld && rx_in.last && en;
  assign dk = pos - ({4'h0, n} + 9'd8);
  assign rk = pos - `MBA_POS_RWDATA;
  assign di = txi - 9'd9;
  assign ttot = rl[8:0] + 9'd6;
  assign mem_raddr = rs[6:0] + di[7:1];

  // Response byte for index txi.
  always_comb begin
    logic [8:0] j;
    j = txi - ({4'h0, n} + 9'd8);
    txb = 8'h00;
    unique case (txi)
      9'd0: txb = fb[0];
      9'd1: txb = fb[1];
      9'd2: txb = fb[2];
      9'd3: txb = fb[3];
      9'd4: txb = rl[15:8];
      9'd5: txb = rl[7:0];
      9'd6: txb = fb[6];
      9'd7: txb = (kind == K_RW || kind == K_ODOK) ? fc :
        (fc | `MBA_FC_ERR);
      default: begin
        unique case (kind)
          K_RW: txb = txi == 9'd8 ? {rc[6:0], 1'b0} :
            (di[0] ? mem_rdata[7:0] : mem_rdata[15:8]);
          K_EXC: txb = excode;
          K_ODOK: begin
            if (txi < {4'h0, n} + 9'd6) begin
              txb = fb[txi[4:0]];
            end else if (txi == {4'h0, n} + 9'd7) begin
              txb = {5'h00, odr.rlen};
            end else if (txi > {4'h0, n} + 9'd7) begin
              // Values go out least significant byte first.
              txb = odr.rdata[{j[1:0], 3'b000} +: 8];
            end
          end
          K_ODERR: begin
            unique case (txi)
              9'd8: txb = `MBA_EXC_EXT;
              9'd9: txb = 8'h00;
              9'd10: txb = `MBA_ODERR_XLEN;
              9'd11: txb = `MBA_MEI_OD;
              9'd12: txb = `MBA_EXC_OD;
              9'd13: txb = odr.code[31:24];
              9'd14: txb = odr.code[23:16];
              9'd15: txb = odr.code[15:8];
              default: txb = odr.code[7:0];
            endcase
          end
          default: txb = 8'h00;
        endcase
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_kind = kind;
    next_fb = fb;
    next_pos = pos;
    next_txi = txi;
    next_tph = tph;
    next_hi_byte = hi_byte;
    next_excode = excode;
    next_rl = rl;
    next_frames = frames;
    next_wdat = wdat;
    next_wlen = wlen;
    next_odr = odr;
    next_tx = '0;
    next_req = od_req;
    next_req.vld = 1'b0;
    ev = 3'b000;
    mem_we = 1'b0;
    mem_waddr = ws[6:0] + rk[7:1];
    unique case (st)
      ST_RX: begin
        // Bytes arriving while an answer is pending are dropped.
        if (rx_in.vld) begin
          next_pos = rx_in.last ? 9'h000 : pos + 9'h001;
          if (pos < 9'd24) begin
            next_fb[pos[4:0]] = rx_in.data;
          end
          if (pos == 9'h000) begin
            next_wlen = 3'h0;
            next_wdat = 32'h0000_0000;
          end
          if (fc == `MBA_FC_RW && pos >= `MBA_POS_RWDATA) begin
            if (!rk[0]) begin
              next_hi_byte = rx_in.data;
            end else if (cnt_ok && en && rk[8:1] < wc[7:0] &&
                         len == `MBA_RW_LEN0 + {wc[14:0], 1'b0}) begin
              // Stored as they arrive, so later reads see them.
              mem_we = 1'b1;
            end
          end
          if (fc == `MBA_FC_EIT && pos >= {4'h0, n} + 9'd8 &&
              dk < 9'd4) begin
            next_wdat[{dk[1:0], 3'b000} +: 8] = rx_in.data;
            next_wlen = dk[2:0] + 3'd1;
          end
        end
        if (fin) begin
          next_txi = 9'h000;
          next_tph = 1'b0;
          if (fc == `MBA_FC_RW) begin
            next_st = ST_TX;
            if (rw_ok) begin
              next_kind = K_RW;
              next_rl = `MBA_RW_RLEN0 + {rc[14:0], 1'b0};
            end else begin
              next_kind = K_EXC;
              next_excode = `MBA_EXC_VALUE;
              next_rl = `MBA_RW_RLEN0;
            end
          end else if (fc == `MBA_FC_EIT) begin
            if (od_ok) begin
              next_st = ST_OD;
              next_req.vld = 1'b1;
              next_req.multi = c0[`MBA_PC_MULTI];
              next_req.write = c0[`MBA_PC_ACC];
              next_req.cnt_on = cb;
              next_req.counter = cb ? fb[n - 5'd1] : 8'h00;
              next_req.node = fb[n];
              next_req.index = {fb[n + 5'd1], fb[n + 5'd2]};
              next_req.sub = fb[n + 5'd3];
              next_req.start = {fb[n + 5'd4], fb[n + 5'd5]};
              next_req.count = odcnt;
              next_req.wdata = next_wdat;
              next_req.wlen = next_wlen;
              ev[2] = 1'b1;
            end else begin
              next_st = ST_TX;
              next_kind = K_ODERR;
              next_odr.code = `MBA_OD_LOCAL_ERR;
              next_rl = `MBA_ODERR_LEN;
            end
          end else begin
            next_st = ST_TX;
            next_kind = K_EXC;
            next_excode = `MBA_EXC_ILLFC;
            next_rl = `MBA_RW_RLEN0;
          end
        end
      end
      ST_OD: begin
        if (od_done) begin
          next_st = ST_TX;
          next_odr = od_resp;
          if (od_resp.err) begin
            next_kind = K_ODERR;
            next_rl = `MBA_ODERR_LEN;
          end else begin
            next_kind = K_ODOK;
            if (od_req.write) begin
              next_odr.rlen = 3'h0;
            end
            next_rl = {11'h000, n} + 16'd2 +
              {13'h0000, next_odr.rlen};
          end
        end
      end
      ST_TX: begin
        // Odd cycles fetch the register word, even cycles send.
        next_tph = !tph;
        if (tph) begin
          next_tx.vld = 1'b1;
          next_tx.data = txb;
          next_tx.last = txi == ttot - 9'd1;
          next_txi = txi + 9'd1;
          if (next_tx.last) begin
            next_st = ST_RX;
            next_frames = frames + 16'd1;
            ev[0] = kind == K_RW || kind == K_ODOK;
            ev[1] = kind == K_EXC || kind == K_ODERR;
          end
        end
      end
      default: next_st = ST_RX;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st <= ST_RX;
      kind <= K_RW;
      fb <= '0;
      pos <= 9'h000;
      txi <= 9'h000;
      tph <= 1'b0;
      hi_byte <= 8'h00;
      excode <= 8'h00;
      rl <= 16'h0000;
      frames <= 16'h0000;
      wdat <= 32'h0000_0000;
      wlen <= 3'h0;
      odr <= '0;
      tx_out <= '0;
      od_req <= '0;
    end else begin
      st <= next_st;
      kind <= next_kind;
      fb <= next_fb;
      pos <= next_pos;
      txi <= next_txi;
      tph <= next_tph;
      hi_byte <= next_hi_byte;
      excode <= next_excode;
      rl <= next_rl;
      frames <= next_frames;
      wdat <= next_wdat;
      wlen <= next_wlen;
      odr <= next_odr;
      tx_out <= next_tx;
      od_req <= next_req;
    end
  end

  mba_regmem u_mem (
    .clk_sys(clk_sys),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata({hi_byte, rx_in.data}),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  mba_csr u_csr (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ev(ev),
    .frames(frames),
    .en(en),
    .irq(irq)
  );

  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_send(logic [8:0] i, mba_kind_t k);
    st == ST_TX && tph && txi == i && kind == k;
  endsequence
  sequence s_err_head;
    tx_out.data == (`MBA_FC_EIT | `MBA_FC_ERR) ##2
    tx_out.data == `MBA_EXC_EXT ##8 tx_out.data == `MBA_EXC_OD;
  endsequence

  AST_RW_FC: assert property (s_send(9'd7, K_RW) |=>
    tx_out.vld && tx_out.data == `MBA_FC_RW)
    else $error("Read/write reply has wrong function code.");
  AST_RW_BC: assert property (s_send(9'd8, K_RW) |=>
    tx_out.data == {rc[6:0], 1'b0})
    else $error("Read/write reply byte count wrong.");
  AST_RW_LEN: assert property (s_send(9'd5, K_RW) |=>
    tx_out.data == 8'(`MBA_RW_RLEN0 + {rc[14:0], 1'b0}))
    else $error("Read/write reply length wrong.");
  AST_BADCNT: assert property (fin && fc == `MBA_FC_RW &&
    (rc == 16'h0000 || rc > `MBA_CNT_MAX) |=> kind == K_EXC && st == ST_TX)
    else $error("Invalid read count not refused.");
  AST_WR_FIRST: assert property (mem_we |-> st == ST_RX &&
    $past(st) != ST_TX)
    else $error("Register written while reads are being sent.");
  AST_OD_FLAGS: assert property ($rose(od_req.vld) |->
    od_req.write == $past(c0[`MBA_PC_ACC]) &&
    od_req.multi == $past(c0[`MBA_PC_MULTI]))
    else $error("Dictionary request flags not taken from control byte.");
  AST_NODE: assert property (od_req.vld |->
    od_req.node >= `MBA_NODE_MIN && od_req.node <= `MBA_NODE_MAX &&
    od_req.count <= `MBA_OD_CNT_MAX)
    else $error("Dictionary request address out of range.");
  AST_ODERR: assert property (s_send(9'd7, K_ODERR) |=> s_err_head)
    else $error("Dictionary error reply malformed.");
  AST_UNSUP: assert property (fin && fc == `MBA_FC_EIT &&
    (c0 & `MBA_PC_MUSTZERO) != 8'h00 |=> kind == K_ODERR ##[1:2] tx_out.vld)
    else $error("Unsupported control bits not refused.");
  AST_MEI: assert property (s_send(9'd8, K_ODOK) |=>
    tx_out.data == `MBA_MEI_OD)
    else $error("Dictionary reply lacks MEI type.");
endmodule : mba_top

// [tb/mba_od_model.sv]
// Behavioural dictionary back end answering after a variable delay.
`timescale 1ns/1ps
module mba_od_model
  import mba_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Dictionary access port
  input wire mba_od_req_t od_req,
  output logic od_done,
  output mba_od_resp_t od_resp
);
  logic busy;
  logic [3:0] dly;
  always_ff @(posedge clk_sys) begin
    od_done <= 1'b0;
    // Outside an answer the response toggles, so a stale value never passes.
    od_resp <= ~od_resp;
    if (!nrst) begin
      busy <= 1'b0;
      dly <= 4'h0;
      od_resp <= '0;
    end else if (od_req.vld) begin
      // The subindex sets the delay, so answers come both prompt and slow.
      busy <= 1'b1;
      dly <= od_req.sub[3:0];
    end else if (busy && dly == 4'h0) begin
      busy <= 1'b0;
      od_done <= 1'b1;
      od_resp.err <= od_req.index == 16'hFFFF;
      od_resp.code <= {od_req.start, od_req.index};
      od_resp.rlen <= od_req.write ? 3'h0 :
        (od_req.count > 16'h0004 ? 3'h4 : od_req.count[2:0]);
      od_resp.rdata <= {od_req.index, od_req.start};
    end else if (busy) begin
      dly <= dly - 4'h1;
    end
  end
endmodule : mba_od_model

// [tb/mba_top_bench.sv]
// Bench of the interpreter: random and corner frames, registers, interrupt.
`timescale 1ns/1ps
`include "mba_map.svh"
module mba_top_bench
  import mba_pkg::*;
;
  typedef logic [7:0] mba_bq_t [$];
  logic clk_sys, nrst, od_done, reg_wr, reg_rd, irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd;
  mba_byte_t rx_in, tx_out;
  mba_od_req_t od_req, oq;
  mba_od_resp_t od_resp;
  mba_bq_t f, e, txq;
  logic [15:0] mem [128];
  int num_errors, samples_checked, n_rep, got;
  bit quiet;
  mba_top u_mba_top (
    .clk_sys(clk_sys), .nrst(nrst), .rx_in(rx_in), .tx_out(tx_out),
    .od_req(od_req), .od_done(od_done), .od_resp(od_resp),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );
  mba_od_model u_mba_od_model (
    .clk_sys(clk_sys), .nrst(nrst), .od_req(od_req), .od_done(od_done),
    .od_resp(od_resp)
  );
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (tx_out.vld === 1'b1) begin
      txq.push_back(tx_out.data);
      if (tx_out.last === 1'b1) got++;
    end
    if (od_req.vld === 1'b1) oq = od_req;
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, s, x);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  function automatic mba_bq_t hd(input logic [15:0] t, l, input logic [7:0] u);
    return {t[15:8], t[7:0], 8'h00, 8'h00, l[15:8], l[7:0], u};
  endfunction : hd
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rdr(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdr
  task irq_is(input logic x);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, x);
  endtask : irq_is
  // Sends frame f and compares the reply with e, or expects silence.
  task xfer;
    int g, k;
    txq.delete();
    g = got;
    for (k = 0; k < f.size(); k++) begin
      @(posedge clk_sys);
      rx_in <= {1'b1, k == f.size() - 1, f[k]};
    end
    @(posedge clk_sys);
    rx_in <= '0;
    for (k = 0; k < 3000 && got == g; k++) @(posedge clk_sys);
    if (quiet) begin
      chk(txq.size(), 0);
    end else begin
      n_rep++;
      chk(txq.size(), e.size());
      for (k = 0; k < e.size(); k++) chk(txq[k], e[k]);
    end
  endtask : xfer
  task rw(input logic [15:0] rs, rc, ws, wc, input int bca, la);
    logic [15:0] v, tid;
    logic [7:0] u;
    int k;
    bit ok;
    tid = 16'($urandom);
    u = 8'($urandom);
    ok = rc >= 1 && rc <= 16'h79 && wc >= 1 && wc <= 16'h79 && bca + la == 0;
    f = {hd(tid, 0, u), 8'h17, rs[15:8], rs[7:0], rc[15:8], rc[7:0],
      ws[15:8], ws[7:0], wc[15:8], wc[7:0], 8'(2 * wc + bca)};
    for (k = 0; k < wc; k++) begin
      v = 16'($urandom);
      f = {f, v[15:8], v[7:0]};
      if (ok) mem[7'(ws + k)] = v;
    end
    v = 16'(f.size() - 6 + la);
    f[4] = v[15:8];
    f[5] = v[7:0];
    e = {hd(tid, 3, u), 8'h97, 8'h03};
    if (ok) begin
      e = {hd(tid, 16'(3 + 2 * rc), u), 8'h17, 8'(2 * rc)};
      for (k = 0; k < rc; k++) begin
        v = mem[7'(rs + k)];
        e = {e, v[15:8], v[7:0]};
      end
    end
    xfer();
  endtask : rw
  task od(input logic [7:0] c0, rv, nd, input logic [15:0] ix,
    input logic [7:0] sb, input logic [15:0] st, cn);
    logic [15:0] v, tid;
    logic [7:0] u;
    logic [31:0] wd, cd;
    int k, np, rl, dn;
    bit bad;
    tid = 16'($urandom);
    u = 8'($urandom);
    f = {hd(tid, 0, u), 8'h2B, 8'h0D, c0};
    if (c0[6]) f.push_back(8'h00);
    f.push_back(rv);
    if (c0[5]) f.push_back(8'($urandom));
    np = f.size();
    f = {f, nd, ix[15:8], ix[7:0], sb, st[15:8], st[7:0], cn[15:8], cn[7:0]};
    dn = c0[0] ? int'(cn) : 0;
    wd = '0;
    for (k = 0; k < dn; k++) begin
      f.push_back(8'($urandom));
      if (k < 4) wd[8 * k +: 8] = f[f.size() - 1];
    end
    v = 16'(f.size() - 6);
    f[4] = v[15:8];
    f[5] = v[7:0];
    bad = (c0 & 8'h1E) != 0 || rv != 0 || nd == 0 || nd > 8'h7F || cn > 16'hFD;
    rl = (c0[0] || bad) ? 0 : (cn > 4 ? 4 : int'(cn));
    cd = bad ? `MBA_OD_LOCAL_ERR : {st, ix};
    e = {hd(tid, 16'h000B, u), 8'hAB, 8'hFF, 8'h00, 8'h06, 8'h0D, 8'hCE,
      cd[31:24], cd[23:16], cd[15:8], cd[7:0]};
    if (!bad && ix != 16'hFFFF) begin
      e = {hd(tid, 16'(np + 2 + rl), u), 8'h2B};
      for (k = 8; k <= np + 5; k++) e.push_back(f[k]);
      e = {e, 8'h00, 8'(rl)};
      cd = {ix, st};
      for (k = 0; k < rl; k++) e.push_back(cd[8 * k +: 8]);
    end
    oq = '0;
    xfer();
    chk(oq.vld, !bad);
    if (!bad) begin
      chk({oq.write, oq.multi, oq.node}, {c0[0], c0[7], nd});
      chk(oq.cnt_on, c0[5]);
      if (c0[5]) chk(oq.counter, f[np - 1]);
      chk({oq.index, oq.sub}, {ix, sb});
      chk({oq.start, oq.count}, {st, cn});
      chk(oq.wdata, wd);
      chk(oq.wlen, dn > 4 ? 4 : dn);
    end
  endtask : od
  initial begin
    repeat (80000) @(posedge clk_sys);
    num_errors++;
    $display("ERROR %0t: run did not finish in time", $time);
    results();
  end
  initial begin
    logic [15:0] a, n;
    int k;
    nrst = 1'b0;
    rx_in = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    void'($urandom(32'hBAC8271B));
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rdr(`MBA_REG_CTRL);
    chk(rd, 16'h0001);
    rdr(`MBA_REG_FRAMES);
    chk(rd, 16'h0000);
    rdr(4'hF);
    chk(rd, 16'h0000);
    rdr(`MBA_REG_STAT);
    chk(rd, 16'h0000);
    @(posedge clk_sys);
    #1 chk(reg_rdata, 16'h0000);
    chk(irq, 1'b0);
    wr(`MBA_REG_MASK, 16'h0001);
    $display("test reset done");
    rw(16'h0010, 16'h0079, 16'h0010, 16'h0079, 0, 0);
    rw(16'hFFFE, 16'h0004, 16'hFFFE, 16'h0004, 0, 0);
    for (k = 0; k < 6; k++) begin
      n = 16'(1 + $urandom % 8);
      a = 16'($urandom);
      rw(a, n, a, n, 0, 0);
    end
    rdr(`MBA_REG_STAT);
    chk(rd, 16'h0001);
    irq_is(1'b1);
    wr(`MBA_REG_MASK, 16'h0000);
    irq_is(1'b0);
    wr(`MBA_REG_MASK, 16'h0001);
    irq_is(1'b1);
    wr(`MBA_REG_STAT, 16'h0001);
    irq_is(1'b0);
    $display("test read write done");
    rw(16'h0020, 16'h0000, 16'h0020, 16'h0001, 0, 0);
    rw(16'h0020, 16'h007A, 16'h0020, 16'h0001, 0, 0);
    rw(16'h0020, 16'h0001, 16'h0020, 16'h0000, 0, 0);
    rw(16'h0020, 16'h0001, 16'h0020, 16'h007A, 0, 0);
    rw(16'h0020, 16'h0001, 16'h0020, 16'h0001, 1, 0);
    rw(16'h0020, 16'h0001, 16'h0020, 16'h0001, 0, 1);
    f = {hd(16'h0001, 16'h0006, 8'h00), 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    e = {hd(16'h0001, 16'h0003, 8'h00), 8'h83, 8'h01};
    xfer();
    rdr(`MBA_REG_STAT);
    chk(rd, 16'h0002);
    irq_is(1'b0);
    wr(`MBA_REG_MASK, 16'h0007);
    irq_is(1'b1);
    $display("test exceptions done");
    od(8'h01, 8'h00, 8'h01, 16'h6060, 8'h00, 16'h0000, 16'h0001);
    od(8'hE0, 8'h00, 8'h7F, 16'h6041, 8'h05, 16'h0000, 16'h0002);
    od(8'h00, 8'h00, 8'h01, 16'h2031, 8'h00, 16'h0000, 16'h00FD);
    od(8'h21, 8'h00, 8'h01, 16'h2031, 8'h03, 16'h0000, 16'h0006);
    od(8'h00, 8'h00, 8'h01, 16'hFFFF, 8'h02, 16'h1234, 16'h0001);
    for (k = 0; k < 4; k++) od(8'(2 << k), 0, 1, 16'h1000, 0, 0, 1);
    od(8'h00, 8'h01, 8'h01, 16'h1000, 8'h00, 16'h0000, 16'h0001);
    od(8'h00, 8'h00, 8'h00, 16'h1000, 8'h00, 16'h0000, 16'h0001);
    od(8'h00, 8'h00, 8'h80, 16'h1000, 8'h00, 16'h0000, 16'h0001);
    od(8'h00, 8'h00, 8'h01, 16'h1000, 8'h00, 16'h0000, 16'h00FE);
    for (k = 0; k < 8; k++) begin
      a = 16'(8'($urandom) & 8'hE1);
      od(a[7:0], 0, 8'(1 + $urandom % 127), 16'($urandom), 8'($urandom),
        16'($urandom), 16'(1 + $urandom % 6));
    end
    rdr(`MBA_REG_STAT);
    chk({rd[2], rd[0]}, 2'b11);
    $display("test dictionary done");
    rdr(`MBA_REG_FRAMES);
    chk(rd, 16'(n_rep));
    quiet = 1'b1;
    wr(`MBA_REG_CTRL, 16'h0000);
    rw(16'h0001, 16'h0001, 16'h0001, 16'h0001, 0, 0);
    quiet = 1'b0;
    wr(`MBA_REG_CTRL, 16'h0001);
    rdr(`MBA_REG_FRAMES);
    chk(rd, 16'(n_rep));
    rw(16'h0002, 16'h0001, 16'h0002, 16'h0001, 0, 0);
    $display("test disable done");
    results();
  end
endmodule : mba_top_bench
